// *** core/acc_top.sv ***
// converter configuration, calibration and run control with its register port
// Operation
// R1: settling select gives 4.3, 2.3 or 1.3 ms wait; code 11 reserved.
// R2: filter cut-off codes map 6.5 Hz to 600 Hz; code 7 gives 240 Hz.
// R3: main and aux gain is 9 bits, msb in bit 7 of second register.
// R4: main and aux offset is a 7-bit field in bits 6:0.
// R5: every reset copies stored calibration words into gain and offset registers.
// R6: current gain joins 8 low bits with bits 7:5 of second register.
// R7: current conversion time select gives 768 us up to 12.288 ms.
// R8: start bit written 1 starts with current settings, reads 0, latches settings.
// R9: main mode: off, eight rounds then stop, continuous, reserved.
// R10: aux mode: off, one round then stop, continuous until new command.
// R11: aux cell select 0 cycles active cells; 0x02 to 0x11 lock one.
// R12: inactive or reserved cell select skips the conversion slot.
// R13: separate filter enables for cell and shunt results, own cut-offs.
// R14: six-bit delay holds off conversion start in 5 us steps to 200 us.
// R15: aux input select 0 cycles all analog inputs; 1 to 8 lock one.
module acc_top #(
  parameter int SETTLE_CYC [0:2] = '{(acc_pkg::SETTLE_NS[0] + acc_pkg::CLK_NS - 1) / acc_pkg::CLK_NS,
                                     (acc_pkg::SETTLE_NS[1] + acc_pkg::CLK_NS - 1) / acc_pkg::CLK_NS,
                                     (acc_pkg::SETTLE_NS[2] + acc_pkg::CLK_NS - 1) / acc_pkg::CLK_NS},
  parameter int CS_CYC [0:3]     = '{acc_pkg::CSDR_NS[0] / acc_pkg::CLK_NS,
                                     acc_pkg::CSDR_NS[1] / acc_pkg::CLK_NS,
                                     acc_pkg::CSDR_NS[2] / acc_pkg::CLK_NS,
                                     acc_pkg::CSDR_NS[3] / acc_pkg::CLK_NS},
  parameter int DLY_STEP_CYC     = acc_pkg::DLY_STEP_NS / acc_pkg::CLK_NS
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [acc_pkg::AW-1:0]     addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic [7:0]                      rdata,
  input  wire logic [8*acc_pkg::NCAL-1:0] otp_cal,
  input  wire logic [15:0]                active_cells,
  input  wire logic [7:0]                 gpio_adc,
  input  wire logic                       main_rr_done,
  input  wire logic                       aux_rr_done,
  output logic                            main_run,
  output logic                            main_start,
  output logic                            aux_run,
  output logic                            aux_start,
  output logic [8:0]                      main_gain,
  output logic [6:0]                      main_offset,
  output logic [8:0]                      aux_gain,
  output logic [6:0]                      aux_offset,
  output logic [10:0]                     cs_gain,
  output logic [4:0]                      cs_offset,
  output logic                            cell_filter_enable,
  output logic                            shunt_filter_enable,
  output logic [acc_pkg::CUT_W-1:0]       cell_filter_cutoff,
  output logic [acc_pkg::CUT_W-1:0]       shunt_filter_cutoff,
  output logic [acc_pkg::SET_W-1:0]       aux_settling_time_sel_cyc,
  output logic [acc_pkg::CS_W-1:0]        current_conv_cyc,
  output logic [15:0]                     aux_cell_mask,
  output logic [7:0]                      aux_gpio_mask,
  output logic                            aux_align
);
  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // address to {hit, index}; shared by the write and read paths
  function automatic logic [4:0] acc_decode(input logic [acc_pkg::AW-1:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < acc_pkg::NREG; i++)
    begin
      if (a == acc_pkg::OFS[i])
        r = {1'b1, 4'(i)};
    end
    return r;
  endfunction : acc_decode

  // cut-off table lookup, used by both filters
  function automatic logic [acc_pkg::CUT_W-1:0] acc_cutoff(input logic [2:0] code);
    return acc_pkg::CUT_DHZ[code];
  endfunction : acc_cutoff

  ////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] cfg [0:acc_pkg::NCFG-1];
  logic [7:0] next_cfg [0:acc_pkg::NCFG-1];
  logic       load_pend;
  logic [4:0] wdec;
  logic [4:0] rdec;
  logic       wr_hit;
  logic       main_go;
  logic       aux_go;
  logic [7:0] next_rdata;

  assign wdec   = acc_decode(addr);
  assign rdec   = wdec;
  assign wr_hit = wr && wdec[4] && (wdec[3:0] != acc_pkg::IX_STAT) && !load_pend;

  // R8: a one on a start bit is a pulse, never stored
  assign main_go = wr_hit && (wdec[3:0] == acc_pkg::IX_CTRL1) && wdata[acc_pkg::GO_BIT];
  assign aux_go  = wr_hit && (wdec[3:0] == acc_pkg::IX_CTRL3) && wdata[acc_pkg::GO_BIT];

  // calibration reload on the first edge after reset, else software writes
  always_comb
  begin
    next_cfg = cfg;
    if (load_pend)
    begin
      // R5: stored calibration words land in the gain and offset registers
      for (int i = 0; i < acc_pkg::NCAL; i++)
        next_cfg[int'(acc_pkg::IX_MCAL1) + i] = otp_cal[8*i +: 8];
    end
    else if (wr_hit)
      next_cfg[wdec[3:0]] = wdata & acc_pkg::WMASK[wdec[3:0]];
  end

  // read data stand only in the cycle after the strobe
  always_comb
  begin
    next_rdata = 8'h00;
    if (rd && rdec[4])
    begin
      if (rdec[3:0] == acc_pkg::IX_STAT)
        next_rdata = {6'h00, aux_run, main_run};
      else
        next_rdata = cfg[rdec[3:0]];
    end
  end

  // registers of the register file
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < acc_pkg::NCFG; i++)
        cfg[i] <= acc_pkg::RST_VAL;
      load_pend <= 1'b1;
      rdata     <= 8'h00;
    end
    else
    begin
      cfg       <= next_cfg;
      load_pend <= 1'b0;
      rdata     <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // calibration words, read by the correction step

  // R3: nine-bit gain, msb from the second register
  assign main_gain   = {cfg[acc_pkg::IX_MCAL2][acc_pkg::GAIN_CORR_HIGH_BIT], cfg[acc_pkg::IX_MCAL1]};
  assign aux_gain    = {cfg[acc_pkg::IX_ACAL2][acc_pkg::GAIN_CORR_HIGH_BIT], cfg[acc_pkg::IX_ACAL1]};
  // R4: seven-bit offset in the low bits
  assign main_offset = cfg[acc_pkg::IX_MCAL2][6:0];
  assign aux_offset  = cfg[acc_pkg::IX_ACAL2][6:0];
  // R6: eleven-bit current gain, upper three bits on top
  assign cs_gain     = {cfg[acc_pkg::IX_CCAL2][acc_pkg::CGH_LSB +: 3], cfg[acc_pkg::IX_CCAL1]};
  assign cs_offset   = cfg[acc_pkg::IX_CCAL2][4:0];

  ////////////////////////////////////////////////////////////////////////
  // settings latched by the start bits

  logic [7:0] app1;
  logic [7:0] app2;
  logic [7:0] app3;
  logic [7:0] next_app1;
  logic [7:0] next_app2;
  logic [7:0] next_app3;

  // R8: control changes apply only when the start bit is written again
  always_comb
  begin
    next_app1 = main_go ? (wdata & acc_pkg::WMASK[acc_pkg::IX_CTRL1]) : app1;
    next_app2 = aux_go ? cfg[acc_pkg::IX_CTRL2] : app2;
    next_app3 = aux_go ? (wdata & acc_pkg::WMASK[acc_pkg::IX_CTRL3]) : app3;
  end

  // applied settings
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      app1 <= acc_pkg::RST_VAL;
      app2 <= acc_pkg::RST_VAL;
      app3 <= acc_pkg::RST_VAL;
    end
    else
    begin
      app1 <= next_app1;
      app2 <= next_app2;
      app3 <= next_app3;
    end
  end

  // R13: each filter has its own enable
  assign cell_filter_enable  = app1[acc_pkg::VCEN_BIT];
  assign shunt_filter_enable = app1[acc_pkg::SREN_BIT];
  assign aux_align           = app2[acc_pkg::ALIGN_BIT];

  ////////////////////////////////////////////////////////////////////////
  // derived timing and channel selection

  logic [4:0]                  csel;
  logic [3:0]                  gsel;
  logic [1:0]                  settle_code;
  logic [5:0]                  dly_steps;
  logic [acc_pkg::DLY_W-1:0]   delay_cyc;
  logic [acc_pkg::CUT_W-1:0]   next_cell_cut;
  logic [acc_pkg::CUT_W-1:0]   next_shunt_cut;
  logic [acc_pkg::SET_W-1:0]   next_settle;
  logic [acc_pkg::CS_W-1:0]    next_cs_cyc;
  logic [15:0]                 next_cell_mask;
  logic [7:0]                  next_gpio_mask;

  assign csel        = app2[acc_pkg::CSEL_LSB +: 5];
  assign gsel        = app3[acc_pkg::GSEL_LSB +: 4];
  assign settle_code = cfg[acc_pkg::IX_CONF1][acc_pkg::SETTLE_LSB +: 2];
  assign dly_steps   = cfg[acc_pkg::IX_CONF2][acc_pkg::DLY_LSB +: 6];

  // R14: steps above the longest delay clamp to it
  assign delay_cyc = acc_pkg::DLY_W'(((dly_steps > acc_pkg::DLY_MAX_STEPS) ? acc_pkg::DLY_MAX_STEPS
                                      : dly_steps) * DLY_STEP_CYC);

  // decoded settings; the inputs may move, so masks are recomputed every cycle
  always_comb
  begin
    // R2: cut-off from its own field for each filter
    next_cell_cut  = acc_cutoff(cfg[acc_pkg::IX_CONF1][acc_pkg::VC_LSB +: 3]);
    next_shunt_cut = acc_cutoff(cfg[acc_pkg::IX_CONF1][acc_pkg::SR_LSB +: 3]);
    // R1: reserved settling code keeps the previous wait
    next_settle = aux_settling_time_sel_cyc;
    if (settle_code != acc_pkg::SETTLE_RSVD)
      next_settle = acc_pkg::SET_W'(SETTLE_CYC[settle_code]);
    // R7: current conversion time
    next_cs_cyc = acc_pkg::CS_W'(CS_CYC[app1[acc_pkg::CSDR_LSB +: 2]]);
    // R11: all active cells, or a single locked cell
    next_cell_mask = 16'h0000;
    if (csel == acc_pkg::CSEL_ALL)
      next_cell_mask = active_cells;
    else if (csel >= acc_pkg::CSEL_FIRST && csel <= acc_pkg::CSEL_LAST)
      // R12: a locked cell that is inactive gets no slot
      next_cell_mask = active_cells & (16'h0001 << (csel - acc_pkg::CSEL_FIRST));
    // R15: all analog inputs, one locked input, or none for reserved codes
    next_gpio_mask = 8'h00;
    if (gsel == acc_pkg::GSEL_ALL)
      next_gpio_mask = gpio_adc;
    else if (gsel <= acc_pkg::GSEL_LAST)
      next_gpio_mask = gpio_adc & (8'h01 << (gsel - 4'h1));
  end

  // decoded setting registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cell_filter_cutoff  <= acc_pkg::CUT_DHZ[0];
      shunt_filter_cutoff <= acc_pkg::CUT_DHZ[0];
      aux_settling_time_sel_cyc      <= acc_pkg::SET_W'(SETTLE_CYC[0]);
      current_conv_cyc    <= acc_pkg::CS_W'(CS_CYC[0]);
      aux_cell_mask       <= 16'h0000;
      aux_gpio_mask       <= 8'h00;
    end
    else
    begin
      cell_filter_cutoff  <= next_cell_cut;
      shunt_filter_cutoff <= next_shunt_cut;
      aux_settling_time_sel_cyc      <= next_settle;
      current_conv_cyc    <= next_cs_cyc;
      aux_cell_mask       <= next_cell_mask;
      aux_gpio_mask       <= next_gpio_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // run sequencers

  acc_run_if main_if ();
  acc_run_if aux_if ();

  // the mode that goes with a start is the one written beside it
  assign main_if.go        = main_go;
  assign main_if.mode      = acc_pkg::acc_mode_t'(next_app1[acc_pkg::MODE_LSB +: 2]);
  assign main_if.delay_cyc = delay_cyc;
  assign main_if.rr_done   = main_rr_done;
  assign aux_if.go         = aux_go;
  assign aux_if.mode       = acc_pkg::acc_mode_t'(next_app3[acc_pkg::MODE_LSB +: 2]);
  assign aux_if.delay_cyc  = delay_cyc;
  assign aux_if.rr_done    = aux_rr_done;

  // R9: main converter runs eight rounds in single mode
  acc_run #(
    .ROUNDS (acc_pkg::ROUNDS_MAIN)
  ) u_main_run (
    .clk     (clk),
    .rst     (rst),
    .port_if (main_if.seq)
  );

  // R10: aux converter runs one round in single mode
  acc_run #(
    .ROUNDS (acc_pkg::ROUNDS_AUX)
  ) u_aux_run (
    .clk     (clk),
    .rst     (rst),
    .port_if (aux_if.seq)
  );

  assign main_run   = main_if.run;
  assign main_start = main_if.conv_start;
  assign aux_run    = aux_if.run;
  assign aux_start  = aux_if.conv_start;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  go_reads_zero_a: assert property (rd && addr == acc_pkg::OFS[acc_pkg::IX_CTRL1] |=> !rdata[acc_pkg::GO_BIT]) // R8
    else $error("start bit read back as one");
  otp_load_a: assert property (load_pend && !rst |=> main_gain == {$past(otp_cal[15]), $past(otp_cal[7:0])}) // R5
    else $error("calibration not loaded after reset");
  gain_msb_a: assert property (wr && !load_pend && addr == acc_pkg::OFS[acc_pkg::IX_MCAL2] // R3
    |=> main_gain[8] == $past(wdata[7]) && main_offset == $past(wdata[6:0]))
    else $error("main gain msb or offset misplaced");
  cs_gain_a: assert property (wr && !load_pend && addr == acc_pkg::OFS[acc_pkg::IX_CCAL2] // R6
    |=> cs_gain[10:8] == $past(wdata[7:5]) && cs_offset == $past(wdata[4:0]))
    else $error("current gain upper bits misplaced");
  settle_rsvd_a: assert property (settle_code == acc_pkg::SETTLE_RSVD |=> $stable(aux_settling_time_sel_cyc)) // R1
    else $error("reserved settling code changed the wait");
  cutoff_map_a: assert property (cfg[acc_pkg::IX_CONF1][2:0] == 3'h7 // R2
    |=> cell_filter_cutoff == acc_pkg::CUT_DHZ[5])
    else $error("cut-off code seven is not the 240 Hz setting");
  cell_skip_a: assert property (csel > acc_pkg::CSEL_LAST || csel == 5'h01 |=> aux_cell_mask == 16'h0000) // R12
    else $error("reserved cell select left a slot");
  gpio_skip_a: assert property (gsel > acc_pkg::GSEL_LAST |=> aux_gpio_mask == 8'h00) // R15
    else $error("reserved input select left a slot");
  start_latch_a: assert property (main_go |=> app1[acc_pkg::MODE_LSB +: 2] == $past(wdata[1:0]) // R8
    ##1 ($stable(app1) || $past(main_go)))
    else $error("start did not latch the control settings");
endmodule : acc_top

// *** core/acc_pkg.sv ***
// constants, register map and types of the converter configuration block
package acc_pkg;
  localparam int CLK_NS = 10;
  localparam int AW     = 12;
  localparam int NCFG   = 11;
  localparam int NREG   = 12;

  // register offsets, by index; the last one is the run status word
  localparam logic [11:0] OFS [0:NREG-1] = '{12'h007, 12'h008, 12'h01b, 12'h01c,
    12'h01d, 12'h01e, 12'h01f, 12'h020, 12'h30d, 12'h30e, 12'h30f, 12'h310};
  localparam logic [3:0] IX_CONF1 = 4'h0;
  localparam logic [3:0] IX_CONF2 = 4'h1;
  localparam logic [3:0] IX_MCAL1 = 4'h2;
  localparam logic [3:0] IX_MCAL2 = 4'h3;
  localparam logic [3:0] IX_ACAL1 = 4'h4;
  localparam logic [3:0] IX_ACAL2 = 4'h5;
  localparam logic [3:0] IX_CCAL1 = 4'h6;
  localparam logic [3:0] IX_CCAL2 = 4'h7;
  localparam logic [3:0] IX_CTRL1 = 4'h8;
  localparam logic [3:0] IX_CTRL2 = 4'h9;
  localparam logic [3:0] IX_CTRL3 = 4'ha;
  localparam logic [3:0] IX_STAT  = 4'hb;
  localparam int NCAL = 6;

  // storable bits; start bits and reserved bits of the control registers never hold a one
  localparam logic [7:0] WMASK [0:NCFG-1] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h7b, 8'h3f, 8'h7b};
  localparam logic [7:0] RST_VAL = 8'h00;

  // field positions
  localparam int SETTLE_LSB = 6;
  localparam int SR_LSB     = 3;
  localparam int VC_LSB     = 0;
  localparam int DLY_LSB    = 0;
  localparam int GAIN_CORR_HIGH_BIT  = 7;
  localparam int CGH_LSB    = 5;
  localparam int CSDR_LSB   = 5;
  localparam int SREN_BIT   = 4;
  localparam int VCEN_BIT   = 3;
  localparam int GO_BIT     = 2;
  localparam int MODE_LSB   = 0;
  localparam int ALIGN_BIT  = 5;
  localparam int CSEL_LSB   = 0;
  localparam int GSEL_LSB   = 3;

  // select codes
  localparam logic [4:0] CSEL_ALL   = 5'h00;
  localparam logic [4:0] CSEL_FIRST = 5'h02;
  localparam logic [4:0] CSEL_LAST  = 5'h11;
  localparam logic [3:0] GSEL_ALL   = 4'h0;
  localparam logic [3:0] GSEL_LAST  = 4'h8;
  localparam logic [1:0] SETTLE_RSVD = 2'h3;

  // times in ns, as printed
  localparam int SETTLE_NS [0:2] = '{4300000, 2300000, 1300000};
  localparam int CSDR_NS [0:3]   = '{768000, 1536000, 3072000, 12288000};
  localparam int DLY_STEP_NS     = 5000;
  localparam logic [5:0] DLY_MAX_STEPS = 6'h28;

  localparam int SET_W = 19;
  localparam int CS_W  = 21;
  localparam int DLY_W = 15;
  localparam int CUT_W = 16;

  // filter cut-off in tenths of a hertz, by code
  localparam logic [15:0] CUT_DHZ [0:7] = '{16'h0041, 16'h0082, 16'h0104, 16'h0212,
    16'h0456, 16'h0960, 16'h1770, 16'h0960};

  localparam int ROUNDS_MAIN = 8;
  localparam int ROUNDS_AUX  = 1;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_CONT   = 2'b10,
    MODE_RSVD   = 2'b11
  } acc_mode_t;
endpackage : acc_pkg

// *** core/acc_run_if.sv ***
// control bundle between the register block and one run sequencer
interface acc_run_if;
  logic                             go;
  acc_pkg::acc_mode_t               mode;
  logic [acc_pkg::DLY_W-1:0]        delay_cyc;
  logic                             rr_done;
  logic                             run;
  logic                             conv_start;

  modport ctl (output go, mode, delay_cyc, rr_done, input run, conv_start);
  modport seq (input go, mode, delay_cyc, rr_done, output run, conv_start);
endinterface : acc_run_if

// *** core/acc_run.sv ***
// run sequencer for one converter: start delay, round counting, run flag
module acc_run #(
  parameter int ROUNDS = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  acc_run_if.seq    port_if
);
  localparam int RW = $clog2(ROUNDS + 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } acc_st_t;

  acc_st_t                   state;
  acc_st_t                   next_state;
  logic [acc_pkg::DLY_W-1:0] cnt;
  logic [acc_pkg::DLY_W-1:0] next_cnt;
  logic [RW-1:0]             rounds;
  logic [RW-1:0]             next_rounds;
  logic                      next_start;
  logic                      valid_mode;

  assign valid_mode = (port_if.mode == acc_pkg::MODE_SINGLE) || (port_if.mode == acc_pkg::MODE_CONT);

  // a start always restarts; the mode is the one latched with it
  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    next_rounds = rounds;
    next_start  = 1'b0;
    if (port_if.go)
    begin
      next_rounds = '0;
      // R9: off and reserved modes do not run
      if (!valid_mode)
        next_state = ST_IDLE;
      else if (port_if.delay_cyc == '0)
      begin
        next_state = ST_RUN;
        next_start = 1'b1;
      end
      else
      begin
        next_state = ST_HOLD;
        next_cnt   = port_if.delay_cyc;
      end
    end
    else
    begin
      case (state)
        ST_HOLD:
        begin
          // R14: hold off the conversion for the chained delay
          next_cnt = cnt - 1'b1;
          if (cnt == {{(acc_pkg::DLY_W-1){1'b0}}, 1'b1})
          begin
            next_state = ST_RUN;
            next_start = 1'b1;
          end
        end
        ST_RUN:
        begin
          // R10: single mode stops after its round count
          if (port_if.rr_done)
          begin
            if (port_if.mode == acc_pkg::MODE_SINGLE && rounds == RW'(ROUNDS - 1))
              next_state = ST_IDLE;
            else
              next_rounds = rounds + 1'b1;
          end
        end
        default:
          next_state = state;
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state              <= ST_IDLE;
      cnt                <= '0;
      rounds             <= '0;
      port_if.run        <= 1'b0;
      port_if.conv_start <= 1'b0;
    end
    else
    begin
      state              <= next_state;
      cnt                <= next_cnt;
      rounds             <= next_rounds;
      port_if.run        <= (next_state == ST_RUN);
      port_if.conv_start <= next_start;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  hold_start_a: assert property (state == ST_HOLD && cnt == 1 && !port_if.go // R14
    |=> port_if.conv_start && port_if.run)
    else $error("delay expiry did not start the conversion");
  single_stop_a: assert property (state == ST_RUN && port_if.mode == acc_pkg::MODE_SINGLE && port_if.rr_done // R9
    && rounds == RW'(ROUNDS - 1) && !port_if.go |=> !port_if.run ##1 (!port_if.run || $past(port_if.go)))
    else $error("single run did not stop after its rounds");
  off_mode_a: assert property (port_if.go && !valid_mode |=> !port_if.run && !port_if.conv_start) // R10
    else $error("off mode started a conversion");
endmodule : acc_run

// *** verification/acc_top_bench.sv ***
// self-checking bench for the converter configuration and run control block
module acc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, main_rr_done = 1'b0, aux_rr_done = 1'b0;
  logic [11:0]       addr = 12'h000;
  logic [7:0]        wdata = 8'h00, gpio_adc = 8'h00, rdata, aux_gpio_mask;
  logic [47:0]       otp_cal = 48'h0;
  logic [15:0]       active_cells = 16'h0, aux_cell_mask, cell_filter_cutoff, shunt_filter_cutoff;
  logic              main_run, main_start, aux_run, aux_start, cell_filter_enable, shunt_filter_enable, aux_align;
  logic [8:0]        main_gain, aux_gain;
  logic [6:0]        main_offset, aux_offset;
  logic [10:0]       cs_gain;
  logic [4:0]        cs_offset;
  logic [18:0]       aux_settling_time_sel_cyc;
  logic [20:0]       current_conv_cyc;
  logic [7:0]        mdl [0:10];
  logic [31:0]       seed = 32'hf226139f;
  logic [63:0]       v;
  logic [4:0]        csel [0:4] = '{5'h00, 5'h02, 5'h11, 5'h01, 5'h12};
  logic [3:0]        gsel [0:4] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hf};
  int                cut [0:7] = '{65, 130, 260, 530, 1110, 2400, 6000, 2400};
  int                stl [0:3] = '{43, 23, 13, 13};
  int                cst [0:3] = '{8, 16, 32, 128};
  int                bad_count = 0, tests_run = 0, cycles = 0, n;

  // short counts keep the run brief; all expectations use these figures
  acc_top #(.SETTLE_CYC('{43, 23, 13}), .CS_CYC('{8, 16, 32, 128}), .DLY_STEP_CYC(5)) DUT (.clk, .rst, .addr,
    .wdata, .wr, .rd, .rdata, .otp_cal, .active_cells, .gpio_adc, .main_rr_done, .aux_rr_done, .main_run,
    .main_start, .aux_run, .aux_start, .main_gain, .main_offset, .aux_gain, .aux_offset, .cs_gain, .cs_offset,
    .cell_filter_enable, .shunt_filter_enable, .cell_filter_cutoff, .shunt_filter_cutoff, .aux_settling_time_sel_cyc,
    .current_conv_cyc, .aux_cell_mask, .aux_gpio_mask, .aux_align);

  always #5 clk = ~clk;

  // hang guard: ends the run as a failure
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  // index -1 stands for an unmapped offset
  task automatic wr_reg(input int i, input logic [7:0] d);
    @(posedge clk);
    addr  <= (i < 0) ? 12'h123 : acc_pkg::OFS[i];
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (i >= 0)
      mdl[i] = d & acc_pkg::WMASK[i];
  endtask : wr_reg

  task automatic rd_reg(input int i);
    @(posedge clk);
    addr <= (i < 0) ? 12'h123 : acc_pkg::OFS[i];
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk_val(rdata, (i < 0) ? 8'h00 : mdl[i]);
  endtask : rd_reg

  task automatic pulse(input logic m);
    @(posedge clk);
    main_rr_done <= m;
    aux_rr_done  <= !m;
    @(posedge clk);
    main_rr_done <= 1'b0;
    aux_rr_done  <= 1'b0;
  endtask : pulse

  task automatic chk_cal;
    chk_val(main_gain, {mdl[3][7], mdl[2]});
    chk_val(main_offset, mdl[3][6:0]);
    chk_val(aux_gain, {mdl[5][7], mdl[4]});
    chk_val(aux_offset, mdl[5][6:0]);
    chk_val(cs_gain, {mdl[7][7:5], mdl[6]});
    chk_val(cs_offset, mdl[7][4:0]);
  endtask : chk_cal

  // fresh stored words each time, so a stale copy shows up
  task automatic do_reset;
    @(posedge clk);
    seed = nxt(seed);
    v = {seed, nxt(seed)};
    seed = nxt(seed);
    rst <= 1'b1;
    otp_cal <= v[47:0];
    active_cells <= seed[15:0];
    gpio_adc <= seed[23:16];
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++)
      mdl[i] = (i >= 2 && i < 8) ? v[8*(i-2) +: 8] : 8'h00;
    @(posedge clk);
    for (int i = 0; i < 11; i++)
      rd_reg(i);
    chk_cal();
  endtask : do_reset

  task stop_test;
    $display("mismatches %0d, checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    do_reset();
    for (int i = 2; i < 8; i++)
    begin
      seed = nxt(seed);
      wr_reg(i, seed[7:0]);
    end
    repeat (2) @(posedge clk);
    chk_cal();
    // every cut-off code on both filters; settle code 3 keeps the last wait
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(0, {c[1:0], 3'(7 - c), c[2:0]});
      repeat (3) @(posedge clk);
      #1 chk_val(cell_filter_cutoff, cut[c]);
      chk_val(shunt_filter_cutoff, cut[7-c]);
      chk_val(aux_settling_time_sel_cyc, stl[c%4]);
    end
    // continuous main runs with each conversion time and enable pair
    for (int d = 0; d < 4; d++)
    begin
      wr_reg(8, {1'b0, d[1:0], d[0], d[1], 3'b110});
      #1 chk_val({main_run, main_start}, 2'b11);
      repeat (2) @(posedge clk);
      #1 chk_val(current_conv_cyc, cst[d]);
      chk_val({cell_filter_enable, shunt_filter_enable}, {d[1], d[0]});
      rd_reg(8);
    end
    // a write without the start bit leaves the running settings alone
    wr_reg(8, 8'h00);
    #1 chk_val({main_run, cell_filter_enable, shunt_filter_enable}, 3'b111);
    wr_reg(8, 8'h07);
    repeat (2) @(posedge clk);
    #1 chk_val(main_run, 1'b0);
    wr_reg(8, 8'h05);
    repeat (7) pulse(1'b1);
    repeat (2) @(posedge clk);
    #1 chk_val(main_run, 1'b1);
    pulse(1'b1);
    repeat (2) @(posedge clk);
    #1 chk_val(main_run, 1'b0);
    // aux starts held off by two delay steps, one per select pair
    wr_reg(1, 8'h02);
    for (int k = 0; k < 5; k++)
    begin
      wr_reg(9, {2'b00, k[0], csel[k]});
      wr_reg(10, {1'b0, gsel[k], 3'b110});
      n = 0;
      #1;
      while (aux_start !== 1'b1 && n < 100)
      begin
        @(posedge clk);
        #1 n++;
      end
      chk_val(n, 10);
      repeat (2) @(posedge clk);
      #1 chk_val(aux_cell_mask, (csel[k] == 0) ? active_cells : (csel[k] >= 2 && csel[k] <= 17) ?
        (16'h1 << (csel[k] - 2)) & active_cells : 16'h0);
      chk_val(aux_gpio_mask, (gsel[k] == 0) ? gpio_adc : (gsel[k] <= 8) ? (8'h1 << (gsel[k] - 1)) & gpio_adc
        : 8'h0);
      chk_val(aux_align, k[0]);
    end
    pulse(1'b0);
    repeat (2) @(posedge clk);
    #1 chk_val(aux_run, 1'b1);
    wr_reg(10, 8'h05);
    repeat (14) @(posedge clk);
    pulse(1'b0);
    repeat (2) @(posedge clk);
    #1 chk_val(aux_run, 1'b0);
    wr_reg(-1, 8'hff);
    rd_reg(-1);
    rd_reg(10);
    stop_test();
  end
endmodule : acc_top_bench
